// *** epc_regs.svh ***
// Register offsets, field positions and reset values of the exception and PC chain unit.
// Assumes byte addressing on a 32-bit AXI4-Lite register bus.
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EPC_OFS_CUR_PSW 8'h00
`define EPC_OFS_SAVED_PSW 8'h04
`define EPC_OFS_CHAIN_RD 8'h08
`define EPC_OFS_CHAIN_WR 8'h0c
`define EPC_OFS_CTRL 8'h10
`define EPC_OFS_INT_STAT 8'h14
`define EPC_OFS_INT_MASK 8'h18
`define EPC_OFS_CAUSE 8'h1c

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define EPC_PSW_IE 0
`define EPC_PSW_USER 1
`define EPC_PSW_VMASK 2
`define EPC_PSW_OVF 3
`define EPC_PSW_SAFE 4
`define EPC_PSW_W 5

// ----------------------------------------------------------------
// Control, interrupt status and cause fields
// ----------------------------------------------------------------
`define EPC_CTRL_SHIFT_DIS 0
`define EPC_EV_IRQ 0
`define EPC_EV_OVF 1
`define EPC_EV_TRAP 2
`define EPC_EV_RESTART 3
`define EPC_EV_W 4

// ----------------------------------------------------------------
// Reset values, vectors and timing
// ----------------------------------------------------------------
`define EPC_PSW_RST 5'h10
`define EPC_CHAIN_LEN 4
`define EPC_RESTART_JUMPS 2'h3
`define EPC_INT_VECTOR 32'h0000_0000
`define EPC_TRAP_SPACING_SH 3
`define EPC_RESP_OKAY 2'h0
`define EPC_RESP_SLVERR 2'h2

`endif

// *** epc_pkg.sv ***
// Types shared by the exception and PC chain unit.
// Assumes epc_regs.svh supplies the numeric constants.
package epc_pkg;

   typedef logic [31:0] epc_word_t;

   // One-hot cause of the most recently taken exception.
   typedef enum logic [3:0]
   {
      EPC_CAUSE_NONE = 4'h1,
      EPC_CAUSE_IRQ = 4'h2,
      EPC_CAUSE_OVF = 4'h4,
      EPC_CAUSE_TRAP = 4'h8
   } epc_cause_t;

endpackage : epc_pkg

// *** epc_pc_chain.sv ***
// Exception entry, PC history chain and restart control of a pipelined core.
// Assumes one clock; pipeline strobes are one-cycle pulses on aclk, the
// external interrupt request is asynchronous and software uses AXI4-Lite.
`timescale 1ns/100ps
`include "epc_regs.svh"

module epc_pc_chain
   import epc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_req,
   input wire logic ovf_event,
   input wire logic trap_alu,
   input wire logic [7:0] trap_vector,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_pc,
   input wire logic jump_plain,
   input wire logic jump_restore,
   output logic redirect_valid,
   output logic [31:0] redirect_pc,
   output logic exc_taken,
   output logic system_state,
   output logic chain_safe,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   epc_word_t chain_q [`EPC_CHAIN_LEN];
   logic [`EPC_PSW_W-1:0] cur_psw_q;
   logic [`EPC_PSW_W-1:0] saved_psw_q;
   logic frozen_q;
   logic shift_dis_q;
   logic [1:0] jumps_q;
   logic [`EPC_EV_W-1:0] int_stat_q;
   logic [`EPC_EV_W-1:0] int_mask_q;
   epc_cause_t cause_q;
   logic [7:0] vector_q;
   logic irq_s1_q;
   logic irq_s2_q;
   logic [7:0] awaddr_q;
   logic aw_full_q;
   epc_word_t wdata_q;
   logic [3:0] wstrb_q;
   logic w_full_q;
   logic redirect_valid_q;
   epc_word_t redirect_pc_q;
   logic exc_taken_q;
   logic irq_q;

   // ----------------------------------------------------------------
   // Exception acceptance
   // ----------------------------------------------------------------
   logic take_irq;
   logic take_ovf;
   logic take_trap;
   logic take_any;
   logic wr_go;
   logic rd_go;
   logic chain_rd;
   logic chain_wr;
   logic any_jump;
   logic restart_done;
   logic [`EPC_EV_W-1:0] ev_set;

   // The two-stage synchroniser only feeds the acceptance gate through its
   // second stage, so a metastable first stage never reaches the logic.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
      end
      else
      begin
         irq_s1_q <= irq_req;
         irq_s2_q <= irq_s1_q;
      end
   end

   // Overflow has priority over the interrupt pin, then the trap instruction.
   assign take_ovf = ovf_event && !cur_psw_q[`EPC_PSW_VMASK] && !frozen_q;
   assign take_irq = irq_s2_q && cur_psw_q[`EPC_PSW_IE] && !frozen_q && !take_ovf;
   assign take_trap = trap_alu && !frozen_q && !take_ovf && !irq_s2_q;
   assign take_any = take_irq || take_ovf || take_trap;
   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign chain_rd = rd_go && (s_axi_araddr == `EPC_OFS_CHAIN_RD);
   assign chain_wr = wr_go && (awaddr_q == `EPC_OFS_CHAIN_WR);
   assign any_jump = jump_plain || jump_restore;
   assign restart_done = jump_plain && (jumps_q == `EPC_RESTART_JUMPS - 2'h1);

   // ----------------------------------------------------------------
   // PC history chain
   // ----------------------------------------------------------------
   // Index 0 holds the previous fetch, index 3 the PC fetched four ago.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `EPC_CHAIN_LEN; i++)
            chain_q[i] <= 32'h0000_0000;
      end
      else if (take_any)
      begin
         // Hold RF, ALU and MEM PCs; nothing new enters.
      end
      else if (chain_wr)
      begin
         for (int i = 1; i < `EPC_CHAIN_LEN; i++)
            chain_q[i] <= chain_q[i-1];
         chain_q[0] <= wdata_q;
      end
      else if (chain_rd || any_jump)
      begin
         // Reads and chain jumps consume the oldest entry.
         for (int i = 1; i < `EPC_CHAIN_LEN; i++)
            chain_q[i] <= chain_q[i-1];
      end
      else if (fetch_valid && !frozen_q && !shift_dis_q)
      begin
         for (int i = 1; i < `EPC_CHAIN_LEN; i++)
            chain_q[i] <= chain_q[i-1];
         chain_q[0] <= fetch_pc;
      end
   end

   // ----------------------------------------------------------------
   // Freeze, shift disable and restart progress
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         frozen_q <= 1'b0;
         shift_dis_q <= 1'b0;
         jumps_q <= 2'h0;
      end
      else if (take_any)
      begin
         frozen_q <= 1'b1;
         jumps_q <= 2'h0;
      end
      else if (jump_restore)
      begin
         frozen_q <= 1'b0;
         shift_dis_q <= 1'b0;
         jumps_q <= 2'h1;
      end
      else
      begin
         if (wr_go && awaddr_q == `EPC_OFS_CTRL && wstrb_q[0])
            shift_dis_q <= wdata_q[`EPC_CTRL_SHIFT_DIS];
         if (restart_done)
            jumps_q <= 2'h0;
         else if (jump_plain && jumps_q != 2'h0)
            jumps_q <= jumps_q + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // Status words
   // ----------------------------------------------------------------
   function automatic epc_word_t merge(epc_word_t old, epc_word_t nw, logic [3:0] be);
      epc_word_t r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction : merge

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur_psw_q <= `EPC_PSW_RST;
         saved_psw_q <= `EPC_PSW_RST;
      end
      else if (take_any)
      begin
         saved_psw_q <= cur_psw_q;
         cur_psw_q[`EPC_PSW_IE] <= 1'b0;
         cur_psw_q[`EPC_PSW_USER] <= 1'b0;
         cur_psw_q[`EPC_PSW_OVF] <= take_ovf;
         cur_psw_q[`EPC_PSW_SAFE] <= 1'b0;
      end
      else if (jump_restore)
      begin
         // Safe flag stays clear until the last chain jump.
         cur_psw_q <= saved_psw_q;
         cur_psw_q[`EPC_PSW_IE] <= 1'b1;
         cur_psw_q[`EPC_PSW_USER] <= 1'b1;
         cur_psw_q[`EPC_PSW_SAFE] <= 1'b0;
      end
      else
      begin
         if (restart_done)
            cur_psw_q[`EPC_PSW_SAFE] <= 1'b1;
         if (wr_go && awaddr_q == `EPC_OFS_CUR_PSW)
            cur_psw_q <= `EPC_PSW_W'(merge(32'(cur_psw_q), wdata_q, wstrb_q));
         if (wr_go && awaddr_q == `EPC_OFS_SAVED_PSW)
            saved_psw_q <= `EPC_PSW_W'(merge(32'(saved_psw_q), wdata_q, wstrb_q));
      end
   end

   // ----------------------------------------------------------------
   // Redirects and cause capture
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         redirect_valid_q <= 1'b0;
         redirect_pc_q <= 32'h0000_0000;
         exc_taken_q <= 1'b0;
         cause_q <= EPC_CAUSE_NONE;
         vector_q <= 8'h00;
      end
      else
      begin
         redirect_valid_q <= take_any || any_jump;
         exc_taken_q <= take_any;
         if (take_trap)
         begin
            redirect_pc_q <= 32'(trap_vector) << `EPC_TRAP_SPACING_SH;
            cause_q <= EPC_CAUSE_TRAP;
            vector_q <= trap_vector;
         end
         else if (take_any)
         begin
            redirect_pc_q <= `EPC_INT_VECTOR;
            cause_q <= take_ovf ? EPC_CAUSE_OVF : EPC_CAUSE_IRQ;
         end
         else if (any_jump)
            redirect_pc_q <= chain_q[`EPC_CHAIN_LEN-1];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------------------------------
   always_comb
   begin
      ev_set = '0;
      ev_set[`EPC_EV_IRQ] = take_irq;
      ev_set[`EPC_EV_OVF] = take_ovf;
      ev_set[`EPC_EV_TRAP] = take_trap;
      ev_set[`EPC_EV_RESTART] = restart_done;
   end

   // A new event in the clearing cycle survives because set is ORed last.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_stat_q <= '0;
         int_mask_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         if (wr_go && awaddr_q == `EPC_OFS_INT_STAT && wstrb_q[0])
            int_stat_q <= (int_stat_q & ~wdata_q[`EPC_EV_W-1:0]) | ev_set;
         else
            int_stat_q <= int_stat_q | ev_set;
         if (wr_go && awaddr_q == `EPC_OFS_INT_MASK && wstrb_q[0])
            int_mask_q <= wdata_q[`EPC_EV_W-1:0];
         irq_q <= |(int_stat_q & int_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data are taken in either order; readies stay low until
   // the response is accepted, so only one write is in flight.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EPC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_full_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
               `EPC_OFS_CUR_PSW, `EPC_OFS_SAVED_PSW, `EPC_OFS_CHAIN_WR, `EPC_OFS_CTRL,
               `EPC_OFS_INT_STAT, `EPC_OFS_INT_MASK:
                  s_axi_bresp <= `EPC_RESP_OKAY;
               default:
                  s_axi_bresp <= `EPC_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `EPC_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `EPC_RESP_OKAY;
         case (s_axi_araddr)
            `EPC_OFS_CUR_PSW: s_axi_rdata <= 32'(cur_psw_q);
            `EPC_OFS_SAVED_PSW: s_axi_rdata <= 32'(saved_psw_q);
            `EPC_OFS_CHAIN_RD: s_axi_rdata <= chain_q[`EPC_CHAIN_LEN-1];
            `EPC_OFS_CHAIN_WR: s_axi_rdata <= chain_q[0];
            `EPC_OFS_CTRL: s_axi_rdata <= {30'h0, frozen_q, shift_dis_q};
            `EPC_OFS_INT_STAT: s_axi_rdata <= 32'(int_stat_q);
            `EPC_OFS_INT_MASK: s_axi_rdata <= 32'(int_mask_q);
            `EPC_OFS_CAUSE: s_axi_rdata <= {20'h0, vector_q, cause_q};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `EPC_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   assign redirect_valid = redirect_valid_q;
   assign redirect_pc = redirect_pc_q;
   assign exc_taken = exc_taken_q;
   assign system_state = !cur_psw_q[`EPC_PSW_USER];
   assign chain_safe = cur_psw_q[`EPC_PSW_SAFE];
   assign irq = irq_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   freeze_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (frozen_q && fetch_valid && !chain_rd && !chain_wr && !any_jump && !take_any)
      |=> $stable(chain_q[0]))
      else $error("chain moved while frozen");

   no_nested_a: assert property (@(posedge aclk) disable iff (!aresetn)
      frozen_q |-> !take_any)
      else $error("exception taken while frozen");

   irq_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take_irq |=> !cur_psw_q[`EPC_PSW_IE] && system_state
      && saved_psw_q == $past(cur_psw_q) && frozen_q)
      else $error("interrupt entry state wrong");

   irq_vector_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (take_irq || take_ovf) |=> redirect_valid && redirect_pc == 32'h0)
      else $error("handler not at zero");

   chain_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      chain_rd && !chain_wr && !take_any |=> s_axi_rvalid && s_axi_rdata == $past(chain_q[3])
      && chain_q[3] == $past(chain_q[2]))
      else $error("chain read or shift wrong");

   chain_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      chain_wr && !take_any |=> chain_q[0] == $past(wdata_q) && chain_q[1] == $past(chain_q[0]))
      else $error("chain write wrong");

   restore_jump_a: assert property (@(posedge aclk) disable iff (!aresetn)
      jump_restore && !take_any |=> cur_psw_q[`EPC_PSW_IE] && !system_state
      && !frozen_q && redirect_pc == $past(chain_q[3]) ##1 !cur_psw_q[`EPC_PSW_SAFE])
      else $error("restoring jump wrong");

   plain_jump_a: assert property (@(posedge aclk) disable iff (!aresetn)
      jump_plain && !take_any && !restart_done && !(wr_go && awaddr_q == `EPC_OFS_CUR_PSW)
      |=> $stable(cur_psw_q) && redirect_pc == $past(chain_q[3]))
      else $error("plain jump changed state");

   ovf_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take_ovf |=> cur_psw_q[`EPC_PSW_OVF] && int_stat_q[`EPC_EV_OVF])
      else $error("overflow cause not set");

   trap_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take_trap |=> redirect_pc == {21'h0, $past(trap_vector), 3'h0} && frozen_q)
      else $error("trap vector wrong");

endmodule : epc_pc_chain

// *** epc_pipe_model.sv ***
// Model of the pipeline front end and the external interrupt source.
// Assumes one clock and a synchronous active-low reset shared with the unit.
`timescale 1ns/100ps

module epc_pipe_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic raise,
   input wire logic redirect_valid,
   input wire logic [31:0] redirect_pc,
   output logic irq_req,
   output logic fetch_valid,
   output logic [31:0] fetch_pc,
   output logic [31:0] last_pc
);
   logic [31:0] pc_q;

   // ----------------------------------------------------------------
   // Fetch stream
   // ----------------------------------------------------------------
   // Fetch stops dead while run is low so the chain holds a known history.
   // The fetch address is inverted when idle, so a stale value never looks valid.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_q <= 32'h0000_0100;
         fetch_valid <= 1'b0;
         fetch_pc <= 32'h0000_0000;
         last_pc <= 32'h0000_0000;
         irq_req <= 1'b0;
      end
      else
      begin
         fetch_valid <= run;
         fetch_pc <= run ? pc_q : ~fetch_pc;
         irq_req <= raise;
         if (run)
            last_pc <= pc_q;
         if (redirect_valid)
            pc_q <= redirect_pc;
         else if (run)
            pc_q <= pc_q + 32'h1;
      end
   end
endmodule : epc_pipe_model

// *** exception_pc_chain_tb.sv ***
// Self-checking bench of the exception and PC chain unit.
// Assumes epc_pkg, epc_regs.svh, the unit and the pipeline model are compiled first.
`timescale 1ns/100ps
`include "epc_regs.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: %s", $time, msg); end end

module exception_pc_chain_tb;
   logic aclk, redirect_valid, exc_taken, system_state, chain_safe, irq, irq_req;
   logic fetch_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic aresetn = 1'b0, run = 1'b0, raise = 1'b0, ovf_event = 1'b0, trap_alu = 1'b0;
   logic jump_plain = 1'b0, jump_restore = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] trap_vector = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, redirect_pc, fetch_pc, last_pc, d;
   int n_mismatch = 0, total_checks = 0, n_exc = 0, n;

   epc_pc_chain uut (.aclk, .aresetn, .irq_req, .ovf_event, .trap_alu, .trap_vector,
      .fetch_valid, .fetch_pc, .jump_plain, .jump_restore, .redirect_valid, .redirect_pc,
      .exc_taken, .system_state, .chain_safe, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   epc_pipe_model pipe (.aclk, .aresetn, .run, .raise, .redirect_valid, .redirect_pc,
      .irq_req, .fetch_valid, .fetch_pc, .last_pc);

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk)
      if (exc_taken === 1'b1)
         n_exc <= n_exc + 1;

   // ----------------------------------------------------------------
   // Bus and strobe tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (n_mismatch == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      s_axi_bready <= 1'b0;
      if (i == 50)
      begin
         n_mismatch++;
         $display("unexpected at %0t: write response timeout", $time);
         print_verdict();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (i == 50)
      begin
         n_mismatch++;
         $display("unexpected at %0t: read response timeout", $time);
         print_verdict();
      end
   endtask : rd

   // Strobe select: 0 overflow, 1 trap, 2 plain jump, 3 restoring jump; then ten cycles.
   task automatic pulse(input int s);
      int n0;
      n0 = n_exc;
      @(posedge aclk);
      case (s)
         0: ovf_event <= 1'b1;
         1: trap_alu <= 1'b1;
         2: jump_plain <= 1'b1;
         default: jump_restore <= 1'b1;
      endcase
      @(posedge aclk);
      {ovf_event, trap_alu, jump_plain, jump_restore} <= 4'h0;
      repeat (10) @(negedge aclk);
      n = n_exc - n0;
   endtask : pulse

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_irq();
      int n0;
      logic [31:0] base;
      rd(`EPC_OFS_CUR_PSW);
      `CHK(d[4:0], `EPC_PSW_RST, "status word reset")
      rd(8'h20);
      `CHK(r, `EPC_RESP_SLVERR, "unmapped read response")
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
            wr(`EPC_OFS_CUR_PSW, 32'h13);
         run <= 1'b1;
         repeat (6) @(posedge aclk);
         run <= 1'b0;
         n0 = n_exc;
         raise <= 1'b1;
         repeat (10) @(posedge aclk);
         raise <= 1'b0;
         `CHK(n_exc - n0, k, "interrupt acceptance")
      end
      `CHK(redirect_pc, `EPC_INT_VECTOR, "handler address")
      `CHK(system_state, 1'b1, "system state on entry")
      `CHK(chain_safe, 1'b0, "safe flag on entry")
      // Fetching on while frozen must leave the saved history untouched.
      base = last_pc;
      run <= 1'b1;
      repeat (3) @(posedge aclk);
      run <= 1'b0;
      rd(`EPC_OFS_SAVED_PSW);
      `CHK(d[1:0], 2'b11, "saved status word")
      rd(`EPC_OFS_CUR_PSW);
      `CHK(d[0], 1'b0, "interrupts disabled")
      rd(`EPC_OFS_CTRL);
      `CHK(d[1], 1'b1, "chain frozen")
      pulse(0);
      `CHK(n, 0, "exception while frozen")
      for (int k = 0; k < 3; k++)
      begin
         rd(`EPC_OFS_CHAIN_RD);
         `CHK(d, base - 32'h3 + 32'(k), "chain read value")
      end
   endtask : s_irq

   task automatic s_restore();
      wr(`EPC_OFS_CTRL, 32'h1);
      for (int k = 0; k < 4; k++)
         wr(`EPC_OFS_CHAIN_WR, 32'h200 + 32'(k));
      rd(`EPC_OFS_CHAIN_WR);
      `CHK(d, 32'h203, "chain write value")
      for (int k = 0; k < 3; k++)
      begin
         pulse(k == 0 ? 3 : 2);
         `CHK(redirect_pc, 32'h200 + 32'(k), "chain jump target")
         `CHK(system_state, 1'b0, "user state after return")
         `CHK(chain_safe, k == 2, "safe flag during restart")
      end
      rd(`EPC_OFS_CTRL);
      `CHK(d[1:0], 2'b00, "shifting restored")
      rd(`EPC_OFS_CUR_PSW);
      `CHK(d[0], 1'b1, "interrupts enabled")
      rd(`EPC_OFS_INT_STAT);
      `CHK(d[3:0], 4'h9, "event status")
      `CHK(irq, 1'b0, "masked interrupt line")
      wr(`EPC_OFS_INT_MASK, 32'h9);
      repeat (2) @(negedge aclk);
      `CHK(irq, 1'b1, "unmasked interrupt line")
      wr(`EPC_OFS_INT_STAT, 32'h9);
      repeat (2) @(negedge aclk);
      `CHK(irq, 1'b0, "cleared interrupt line")
   endtask : s_restore

   task automatic s_ovf_trap();
      for (int k = 0; k < 2; k++)
      begin
         wr(`EPC_OFS_CUR_PSW, k ? 32'h1 : 32'h5);
         pulse(0);
         `CHK(n, k, "overflow trap acceptance")
         `CHK(redirect_pc, k ? `EPC_INT_VECTOR : 32'h202, "overflow handler address")
      end
      rd(`EPC_OFS_CUR_PSW);
      `CHK(d[3], 1'b1, "overflow cause bit")
      pulse(3);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge aclk);
         trap_vector <= k ? 8'hff : 8'h00;
         pulse(1);
         `CHK(n, 1, "trap acceptance")
         `CHK(redirect_pc, 32'(trap_vector) << 3, "trap entry address")
         `CHK(system_state, 1'b1, "trap system state")
         rd(`EPC_OFS_CAUSE);
         `CHK(d, {20'h0, trap_vector, 4'h8}, "trap cause")
         rd(`EPC_OFS_CTRL);
         `CHK(d[1], 1'b1, "trap freezes chain")
         pulse(3);
      end
   endtask : s_ovf_trap

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      s_irq();
      s_restore();
      s_ovf_trap();
      print_verdict();
   end
endmodule : exception_pc_chain_tb
